// File: shared/pmc_defs.svh
// Constants of the per-port PHY management control register bank
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_NUM_PORTS      5
`define PMC_PHYAD_FIRST    5'h01
`define PMC_PHYAD_LAST     5'h05
`define PMC_REG_CTRL       5'h00
`define PMC_REG_LAST_STD   5'h05
`define PMC_REG_EXT_A      5'h1D
`define PMC_REG_EXT_B      5'h1F
`define PMC_BIT_RESET      15
`define PMC_BIT_LOOPBACK   14
`define PMC_BIT_SPEED100   13
`define PMC_BIT_AN_ON      12
`define PMC_BIT_PWRDN      11
`define PMC_BIT_ISOLATE    10
`define PMC_BIT_AN_RESTART 9
`define PMC_BIT_FULLDUP    8
`define PMC_BIT_XOVER      5
`define PMC_CTRL_RESET     16'h3020
`define PMC_CTRL_WMASK     16'hFF20

`endif

// File: shared/pmc_pkg.sv
// Types of the per-port PHY management control register bank
package pmc_pkg;
   typedef logic [15:0] pmc_word_t;
   typedef logic [4:0]  pmc_addr_t;
   typedef logic [2:0]  pmc_port_t;
endpackage : pmc_pkg

// File: logic/pmc_regs.sv
// Per-port PHY basic control register bank for management and SPI access
`timescale 1ns/100ps
`include "pmc_defs.svh"

module pmc_regs
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   // Serial management register access (decoded MDIO frame)
   input  wire logic             mdio_req,
   input  wire logic             mdio_wr,
   input  wire pmc_pkg::pmc_addr_t mdio_phyad,
   input  wire pmc_pkg::pmc_addr_t mdio_regad,
   input  wire pmc_pkg::pmc_word_t mdio_wdata,
   output logic                  mdio_ack,
   output pmc_pkg::pmc_word_t    mdio_rdata,
   // SPI register access: port index 0..4 and register address
   input  wire logic             spi_req,
   input  wire logic             spi_wr,
   input  wire pmc_pkg::pmc_port_t spi_port,
   input  wire pmc_pkg::pmc_addr_t spi_regad,
   input  wire pmc_pkg::pmc_word_t spi_wdata,
   output logic                  spi_ack,
   output pmc_pkg::pmc_word_t    spi_rdata,
   // Per-port PHY controls, bit n is port n+1
   output logic [4:0]            phy_soft_reset,
   output logic [4:0]            mac_loopback,
   output logic [4:0]            speed_100,
   output logic [4:0]            autoneg_on,
   output logic [4:0]            power_down,
   output logic [4:0]            line_isolation,
   output logic [4:0]            autoneg_restart,
   output logic [4:0]            full_duplex,
   output logic [4:0]            crossover_scheme_select
);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic reg_supported(input pmc_pkg::pmc_addr_t a);
      reg_supported = (a <= `PMC_REG_LAST_STD) || (a == `PMC_REG_EXT_A)
                      || (a == `PMC_REG_EXT_B);
   endfunction : reg_supported

   function automatic logic port_hit(input pmc_pkg::pmc_addr_t phyad, input int p);
      port_hit = (phyad == 5'(p + 1));
   endfunction : port_hit

   pmc_pkg::pmc_word_t ctrl_r [`PMC_NUM_PORTS];
   pmc_pkg::pmc_word_t mdio_rdata_nxt;
   pmc_pkg::pmc_word_t spi_rdata_nxt;

   // ----------------------------------------
   // Request qualification
   // ----------------------------------------
   logic               mdio_phy_ok;
   logic               mdio_reg_ok;

   // A frame for another PHY on the shared line must stay silent
   assign mdio_phy_ok = (mdio_phyad >= `PMC_PHYAD_FIRST)
                        && (mdio_phyad <= `PMC_PHYAD_LAST);
   // Status and extension registers live outside this bank but still answer
   assign mdio_reg_ok = reg_supported(mdio_regad);

   // ----------------------------------------
   // Control registers, one per port
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `PMC_NUM_PORTS; g = g + 1)
      begin : g_port
         logic m_wr;
         logic s_wr;
         assign m_wr = mdio_req && mdio_wr && port_hit(mdio_phyad, g)
                       && (mdio_regad == `PMC_REG_CTRL);
         assign s_wr = spi_req && spi_wr && (spi_port == 3'(g))
                       && (spi_regad == `PMC_REG_CTRL);

         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
               ctrl_r[g] <= `PMC_CTRL_RESET;
            else if (m_wr)
               ctrl_r[g] <= mdio_wdata & `PMC_CTRL_WMASK;
            else if (s_wr)
               ctrl_r[g] <= spi_wdata & `PMC_CTRL_WMASK;
            else
            begin
               // Soft reset and restart are one-cycle commands
               ctrl_r[g][`PMC_BIT_RESET]      <= 1'b0;
               ctrl_r[g][`PMC_BIT_AN_RESTART] <= 1'b0;
            end
         end

         // Commands: one-cycle pulses that follow the self-clearing bits
         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               phy_soft_reset[g]  <= 1'b0;
               autoneg_restart[g] <= 1'b0;
            end
            else
            begin
               phy_soft_reset[g]  <= ctrl_r[g][`PMC_BIT_RESET];
               autoneg_restart[g] <= ctrl_r[g][`PMC_BIT_AN_RESTART];
            end
         end

         // Line modes forced by the management host
         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               mac_loopback[g]            <= 1'b0;
               speed_100[g]               <= 1'b1;
               power_down[g]              <= 1'b0;
               line_isolation[g]          <= 1'b0;
               full_duplex[g]             <= 1'b0;
               crossover_scheme_select[g] <= 1'b1;
            end
            else
            begin
               mac_loopback[g]            <= ctrl_r[g][`PMC_BIT_LOOPBACK];
               speed_100[g]               <= ctrl_r[g][`PMC_BIT_SPEED100];
               power_down[g]              <= ctrl_r[g][`PMC_BIT_PWRDN];
               line_isolation[g]          <= ctrl_r[g][`PMC_BIT_ISOLATE];
               full_duplex[g]             <= ctrl_r[g][`PMC_BIT_FULLDUP];
               crossover_scheme_select[g] <= ctrl_r[g][`PMC_BIT_XOVER];
            end
         end

         // Negotiation enable
         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
               autoneg_on[g] <= 1'b1;
            else
               autoneg_on[g] <= ctrl_r[g][`PMC_BIT_AN_ON];
         end
      end
   endgenerate

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb
   begin
      mdio_rdata_nxt = 16'h0000;
      for (int p = 0; p < `PMC_NUM_PORTS; p++)
      begin
         if (port_hit(mdio_phyad, p) && (mdio_regad == `PMC_REG_CTRL))
            mdio_rdata_nxt = ctrl_r[p];
      end
   end

   always_comb
   begin
      spi_rdata_nxt = 16'h0000;
      for (int p = 0; p < `PMC_NUM_PORTS; p++)
      begin
         if ((spi_port == 3'(p)) && (spi_regad == `PMC_REG_CTRL))
            spi_rdata_nxt = ctrl_r[p];
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         mdio_ack <= 1'b0;
      else
      begin
         // Only in-range PHY addresses and supported registers answer
         mdio_ack <= mdio_req && mdio_phy_ok && mdio_reg_ok;
      end
   end

   // Read data is zero outside an access so stale words never show
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         mdio_rdata <= 16'h0000;
      else
         mdio_rdata <= mdio_req ? mdio_rdata_nxt : 16'h0000;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         spi_ack <= 1'b0;
      else
         spi_ack <= spi_req;
   end

   // Read data is zero outside an access so stale words never show
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         spi_rdata <= 16'h0000;
      else
         spi_rdata <= spi_req ? spi_rdata_nxt : 16'h0000;
   end

endmodule : pmc_regs

// File: testbench/pmc_mgr_model.sv
// Management controller model issuing single register accesses
`timescale 1ns/100ps
module pmc_mgr_model
(
   input wire logic core_clk,
   output logic req,
   output logic wr,
   output pmc_pkg::pmc_addr_t pa,
   output pmc_pkg::pmc_addr_t ra,
   output pmc_pkg::pmc_word_t wd,
   input wire logic ack,
   input wire pmc_pkg::pmc_word_t rd
);
   pmc_pkg::pmc_word_t q;
   logic k;
   initial {req, wr, pa, ra, wd} = '0;
   // Released data shows its inverse so stale data is never trusted
   task automatic xf(input logic w, input pmc_pkg::pmc_addr_t a, r, input pmc_pkg::pmc_word_t d);
      @(negedge core_clk);
      {req, wr, pa, ra, wd} = {1'b1, w, a, r, d};
      @(negedge core_clk);
      {req, wd} = {1'b0, ~d};
      q = rd;
      k = ack;
   endtask : xf
endmodule : pmc_mgr_model

// File: testbench/pmc_regs_asserts.sv
// Port checks of the PHY control register bank
`timescale 1ns/100ps
module pmc_regs_asserts
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic mdio_req,
   input wire logic mdio_wr,
   input wire pmc_pkg::pmc_addr_t mdio_phyad,
   input wire pmc_pkg::pmc_addr_t mdio_regad,
   input wire pmc_pkg::pmc_word_t mdio_wdata,
   input wire logic mdio_ack,
   input wire pmc_pkg::pmc_word_t mdio_rdata,
   input wire logic spi_req,
   input wire logic spi_ack,
   input wire logic [4:0] phy_soft_reset,
   input wire logic [4:0] mac_loopback,
   input wire logic [4:0] speed_100,
   input wire logic [4:0] autoneg_restart
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire ok = mdio_phyad inside {[5'h01:5'h05]};
   wire reg_ok = mdio_regad <= 5'h05 || mdio_regad inside {5'h1D, 5'h1F};
   wire w1 = mdio_req && mdio_wr && mdio_phyad == 5'h01 && mdio_regad == 5'h00;
   phy_addr_a: assert property (mdio_req && !ok |=> !mdio_ack)
      else $error("foreign ack");
   reg_decode_a: assert property (mdio_req && ok |=> mdio_ack == $past(reg_ok))
      else $error("bad decode");
   spi_ack_a: assert property (spi_req |=> spi_ack)
      else $error("spi ack missing");
   soft_reset_a: assert property (w1 && mdio_wdata[15] ##1 !(w1 && mdio_wdata[15])
      |=> phy_soft_reset[0] ##1 !phy_soft_reset[0]) else $error("soft reset pulse");
   restart_pulse_a: assert property (w1 && mdio_wdata[9] ##1 !(w1 && mdio_wdata[9])
      |=> autoneg_restart[0] ##1 !autoneg_restart[0]) else $error("restart pulse");
   loopback_a: assert property (w1 |-> ##2 mac_loopback[0] == $past(mdio_wdata[14], 2))
      else $error("loopback");
   speed_sel_a: assert property (w1 |-> ##2 speed_100[0] == $past(mdio_wdata[13], 2))
      else $error("speed");
   rsvd_zero_a: assert property (mdio_ack |-> mdio_rdata[7:6] == 2'h0)
      else $error("reserved bits");
   unimpl_zero_a: assert property (mdio_req && !mdio_wr && mdio_regad != 5'h00
      |=> mdio_rdata == 16'h0000) else $error("nonzero read");
   cover property (w1 && mdio_wdata[15]);
   cover property (mdio_req && !ok);
   cover property (spi_req ##1 spi_ack);
endmodule : pmc_regs_asserts

// File: testbench/tb_top.sv
// Self-checking bench for the PHY control register bank
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0, resetn = 1'b0, mdio_req, mdio_wr, mdio_ack, spi_req, spi_wr, spi_ack;
   pmc_pkg::pmc_addr_t mdio_phyad, mdio_regad, spi_regad, spi_pa;
   pmc_pkg::pmc_port_t spi_port;
   pmc_pkg::pmc_word_t mdio_wdata, mdio_rdata, spi_wdata, spi_rdata;
   logic [4:0] phy_soft_reset, mac_loopback, speed_100, autoneg_on, power_down;
   logic [4:0] line_isolation, autoneg_restart, full_duplex, crossover_scheme_select;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   assign spi_port = spi_pa[2:0];
   always #10 core_clk = ~core_clk;
   pmc_regs u_dut (.core_clk, .resetn, .mdio_req, .mdio_wr, .mdio_phyad, .mdio_regad,
      .mdio_wdata, .mdio_ack, .mdio_rdata, .spi_req, .spi_wr, .spi_port, .spi_regad,
      .spi_wdata, .spi_ack, .spi_rdata, .phy_soft_reset, .mac_loopback, .speed_100,
      .autoneg_on, .power_down, .line_isolation, .autoneg_restart, .full_duplex,
      .crossover_scheme_select);
   pmc_mgr_model u_mdio (.core_clk, .req(mdio_req), .wr(mdio_wr), .pa(mdio_phyad),
      .ra(mdio_regad), .wd(mdio_wdata), .ack(mdio_ack), .rd(mdio_rdata));
   pmc_mgr_model u_spi (.core_clk, .req(spi_req), .wr(spi_wr), .pa(spi_pa),
      .ra(spi_regad), .wd(spi_wdata), .ack(spi_ack), .rd(spi_rdata));
   task automatic chk(input pmc_pkg::pmc_word_t got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   function automatic pmc_pkg::pmc_word_t ctl(int i);
      return {9'h000, mac_loopback[i], speed_100[i], autoneg_on[i], power_down[i],
         line_isolation[i], full_duplex[i], crossover_scheme_select[i]};
   endfunction : ctl
   task automatic t_reset;
      chk({1'b0, speed_100, autoneg_on, crossover_scheme_select}, 16'h7FFF);
      chk({1'b0, mac_loopback, power_down, line_isolation}, 16'h0000);
      u_mdio.xf(1'b0, 5'h01, 5'h00, 16'h0000);
      chk(u_mdio.q, 16'h3020);
   endtask : t_reset
   task automatic t_ports;
      for (int p = 1; p <= 5; p++)
      begin
         u_mdio.xf(1'b1, 5'(p), 5'h00, 16'hFFFF);
         u_mdio.xf(1'b0, 5'(p), 5'h00, 16'h0000);
         chk(u_mdio.q, 16'h7D20);
         chk(ctl(p - 1), 16'h007F);
         u_mdio.xf(1'b1, 5'(p), 5'h00, 16'h0000);
         u_mdio.xf(1'b0, 5'(p), 5'h00, 16'h0000);
         chk(ctl(p - 1), 16'h0000);
      end
   endtask : t_ports
   task automatic t_refuse;
      u_mdio.xf(1'b1, 5'h06, 5'h00, 16'hFFFF);
      chk({15'h0, u_mdio.k}, 16'h0000);
      u_mdio.xf(1'b0, 5'h01, 5'h06, 16'h0000);
      chk({15'h0, u_mdio.k}, 16'h0000);
      u_mdio.xf(1'b1, 5'h05, 5'h1D, 16'hFFFF);
      u_mdio.xf(1'b0, 5'h05, 5'h1F, 16'h0000);
      chk({u_mdio.k, u_mdio.q[14:0]}, 16'h8000);
      chk(ctl(4), 16'h0000);
   endtask : t_refuse
   task automatic t_spi;
      u_spi.xf(1'b1, 5'h02, 5'h00, 16'h4100);
      u_mdio.xf(1'b0, 5'h03, 5'h00, 16'h0000);
      chk(u_mdio.q, 16'h4100);
      u_spi.xf(1'b0, 5'h05, 5'h00, 16'h0000);
      chk({u_spi.k, u_spi.q[14:0]}, 16'h8000);
   endtask : t_spi
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      t_reset();
      t_ports();
      t_refuse();
      t_spi();
      wrap_up();
   end
endmodule : tb_top
bind pmc_regs pmc_regs_asserts u_chk (.core_clk, .resetn, .mdio_req, .mdio_wr, .mdio_phyad,
   .mdio_regad, .mdio_wdata, .mdio_ack, .mdio_rdata, .spi_req, .spi_ack, .phy_soft_reset,
   .mac_loopback, .speed_100, .autoneg_restart);
